// ==== result_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

// Result buffer between the converter core and the readout ports.
// The head word sits in a register in front of the memory, so the reader
// always sees registered data and a word that arrives at an empty buffer
// is visible one cycle later.
module result_fifo
#(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
)
(
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             sys_rst,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [AW-1:0]    wp;
		logic [AW-1:0]    rp;
		logic [CW-1:0]    count;
		logic             head_valid;
		logic [WIDTH-1:0] head_data;
	} fifo_state_t;

	fifo_state_t      state_reg;
	fifo_state_t      state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             mem_write;

	// The memory is full when it holds DEPTH words; the head register adds one more slot.
	assign in_ready  = (state_reg.count != CW'(DEPTH));
	assign out_valid = state_reg.head_valid;
	assign out_data  = state_reg.head_data;

	// Refill the head from memory first, so words leave in arrival order.
	always_comb
	begin
		state_next = state_reg;
		mem_write  = in_valid && in_ready;
		if (!state_reg.head_valid || out_ready)
		begin
			if (state_reg.count != '0)
			begin
				state_next.head_data  = mem[state_reg.rp];
				state_next.head_valid = 1'b1;
				state_next.rp         = state_reg.rp + 1'b1;
				state_next.count      = state_reg.count - CW'(1);
			end
			else if (mem_write)
			begin
				state_next.head_data  = in_data;
				state_next.head_valid = 1'b1;
				mem_write             = 1'b0;
			end
			else
			begin
				state_next.head_valid = 1'b0;
			end
		end
		if (mem_write)
		begin
			state_next.wp    = state_reg.wp + 1'b1;
			state_next.count = state_next.count + CW'(1);
		end
	end

	// Storage array carries no reset; only its pointers, count and head register do.
	always_ff @(posedge clock)
	begin
		if (mem_write)
			mem[state_reg.wp] <= in_data;
	end

	// State register.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

endmodule : result_fifo

`default_nettype wire

// ==== adc_conversion_output_timing.sv ====
`timescale 1ns/1ps
`default_nettype none

// Shared constants, types and cycle arithmetic for the converter control.
package adc_timing_pkg;

	localparam int CLK_PERIOD_NS = 100;
	localparam int RESULT_BITS   = 14;
	localparam int FIFO_WORDS    = 16;

	// Longest busy and conversion times per mode.
	localparam int CONV_MAX_NS_FAST   = 850;
	localparam int CONV_MAX_NS_NORMAL = 1100;
	localparam int CONV_MAX_NS_LOW    = 1350;
	// Frame sync delays after the start edge.
	localparam int SYNC_RDC_NS_FAST   = 50;
	localparam int SYNC_RDC_NS_NORMAL = 290;
	localparam int SYNC_RDC_NS_LOW    = 530;
	localparam int SYNC_RAC_NS_FAST   = 710;
	localparam int SYNC_RAC_NS_NORMAL = 950;
	localparam int SYNC_RAC_NS_LOW    = 1190;
	// Serial framing margins.
	localparam int SYNC_LEAD_MIN_NS   = 20;
	localparam int SYNC_HOLD_MIN_NS   = 90;
	localparam int BUSY_TAIL_NS       = 25;

	function automatic int cyc_floor(input int ns);
		cyc_floor = (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
	endfunction : cyc_floor

	function automatic int cyc_ceil(input int ns);
		cyc_ceil = ((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1
			: (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : cyc_ceil

	localparam logic [7:0] CONV_CYC_FAST   = 8'(cyc_floor(CONV_MAX_NS_FAST));
	localparam logic [7:0] CONV_CYC_NORMAL = 8'(cyc_floor(CONV_MAX_NS_NORMAL));
	localparam logic [7:0] CONV_CYC_LOW    = 8'(cyc_floor(CONV_MAX_NS_LOW));
	localparam logic [7:0] RDC_CYC_FAST    = 8'(cyc_floor(SYNC_RDC_NS_FAST));
	localparam logic [7:0] RDC_CYC_NORMAL  = 8'(cyc_floor(SYNC_RDC_NS_NORMAL));
	localparam logic [7:0] RDC_CYC_LOW     = 8'(cyc_floor(SYNC_RDC_NS_LOW));
	localparam logic [7:0] RAC_CYC_FAST    = 8'(cyc_floor(SYNC_RAC_NS_FAST));
	localparam logic [7:0] RAC_CYC_NORMAL  = 8'(cyc_floor(SYNC_RAC_NS_NORMAL));
	localparam logic [7:0] RAC_CYC_LOW     = 8'(cyc_floor(SYNC_RAC_NS_LOW));
	localparam logic [3:0] LEAD_CYC        = 4'(cyc_ceil(SYNC_LEAD_MIN_NS));
	localparam logic [3:0] HOLD_CYC        = 4'(cyc_ceil(SYNC_HOLD_MIN_NS));
	localparam logic [3:0] TAIL_CYC        = 4'(cyc_floor(BUSY_TAIL_NS));
	localparam logic [3:0] LAST_BIT        = 4'(RESULT_BITS - 1);

	typedef enum logic [1:0] {MODE_NORMAL, MODE_LOW_POWER, MODE_FAST} conv_mode_t;
	typedef enum logic [1:0] {C_IDLE, C_CONV, C_READ} conv_state_t;
	typedef enum logic [1:0] {S_IDLE, S_LEAD, S_SHIFT, S_HOLD} ser_state_t;

	typedef struct packed {
		conv_state_t            conv;
		ser_state_t             ser;
		conv_mode_t             mode;
		logic                   rac;
		logic [1:0]             div;
		logic [1:0]             fdiv;
		logic [7:0]             cnt;
		logic                   started;
		logic                   cnv_prev;
		logic                   req_prev;
		logic                   busy;
		logic [RESULT_BITS-1:0] par_data;
		logic                   par_oe_n;
		logic [RESULT_BITS-1:0] shreg;
		logic [3:0]             bit_idx;
		logic [3:0]             tick_cnt;
		logic [3:0]             phase_cnt;
		logic                   sync;
		logic                   sclk;
		logic                   sdo;
		logic                   ser_oe_n;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = '{conv: C_IDLE, ser: S_IDLE, mode: MODE_NORMAL,
		rac: 1'b0, div: 2'h0, fdiv: 2'h0, cnt: 8'h00, started: 1'b0, cnv_prev: 1'b1,
		req_prev: 1'b0, busy: 1'b0, par_data: '0, par_oe_n: 1'b1, shreg: '0,
		bit_idx: 4'h0, tick_cnt: 4'h0, phase_cnt: 4'h0, sync: 1'b0, sclk: 1'b0,
		sdo: 1'b0, ser_oe_n: 1'b1};

	function automatic logic [7:0] conv_cycles(input conv_mode_t m);
		unique case (m)
			MODE_FAST:      conv_cycles = CONV_CYC_FAST;
			MODE_LOW_POWER: conv_cycles = CONV_CYC_LOW;
			MODE_NORMAL:    conv_cycles = CONV_CYC_NORMAL;
		endcase
	endfunction : conv_cycles

	function automatic logic [7:0] rdc_cycles(input conv_mode_t m);
		unique case (m)
			MODE_FAST:      rdc_cycles = RDC_CYC_FAST;
			MODE_LOW_POWER: rdc_cycles = RDC_CYC_LOW;
			MODE_NORMAL:    rdc_cycles = RDC_CYC_NORMAL;
		endcase
	endfunction : rdc_cycles

	function automatic logic [7:0] rac_cycles(input conv_mode_t m);
		unique case (m)
			MODE_FAST:      rac_cycles = RAC_CYC_FAST;
			MODE_LOW_POWER: rac_cycles = RAC_CYC_LOW;
			MODE_NORMAL:    rac_cycles = RAC_CYC_NORMAL;
		endcase
	endfunction : rac_cycles

endpackage : adc_timing_pkg

module adc_conversion_output_timing
(
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Conversion control.
	input  wire logic        convert_start_n,
	input  wire logic        fastest_select,
	input  wire logic        low_power_select,
	input  wire logic [13:0] conv_result,
	output logic             busy,
	// Parallel port.
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	output logic [13:0]      par_data_out,
	output logic             par_data_oe_n,
	// Master serial port.
	input  wire logic        serial_mode,
	input  wire logic        read_after_convert,
	input  wire logic [1:0]  serial_clock_divider,
	output logic             frame_sync_out,
	output logic             frame_sync_oe_n,
	output logic             serial_data_clock,
	output logic             serial_data_clock_oe_n,
	output logic             serial_result_out,
	output logic             serial_result_oe_n
);

	adc_timing_pkg::ctrl_t      r;
	adc_timing_pkg::ctrl_t      n;
	adc_timing_pkg::conv_mode_t mode_sel;
	logic                       par_req;
	logic                       start;
	logic                       capture;
	logic                       frame_go;
	logic                       fifo_push;
	logic                       fifo_pop;
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic [13:0]                fifo_out_data;
	logic [3:0]                 half_last;

	// Mode from the two select levels; both high is treated as normal.
	assign mode_sel = (fastest_select && !low_power_select) ? adc_timing_pkg::MODE_FAST
		: (low_power_select && !fastest_select) ? adc_timing_pkg::MODE_LOW_POWER
		: adc_timing_pkg::MODE_NORMAL;
	assign par_req   = !cs_n && !rd_n && !serial_mode;
	assign half_last = 4'((1 << r.fdiv) - 1);

	// Finished results queue here for the serial engine; each parallel read pops one, while par_data_out shows the latest result.
	result_fifo #(
		.WIDTH (adc_timing_pkg::RESULT_BITS),
		.DEPTH (adc_timing_pkg::FIFO_WORDS)
	) result_fifo_inst (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (conv_result),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	// Conversion sequencer, parallel port and serial framer in one next-state process.
	always_comb
	begin
		n          = r;
		fifo_push  = 1'b0;
		fifo_pop   = 1'b0;
		capture    = 1'b0;
		n.cnv_prev = convert_start_n;
		n.req_prev = par_req;
		n.par_oe_n = !par_req;
		n.ser_oe_n = !(serial_mode && !cs_n);
		// A start while busy or with the buffer full is ignored, which also
		// shields the core from starts closer than the minimum spacing.
		start = r.cnv_prev && !convert_start_n && (r.conv == adc_timing_pkg::C_IDLE)
			&& fifo_in_ready;
		unique case (r.conv)
			adc_timing_pkg::C_IDLE:
			begin
				if (start)
				begin
					n.conv    = adc_timing_pkg::C_CONV;
					n.cnt     = 8'h01;
					n.busy    = 1'b1;
					n.mode    = mode_sel;
					n.rac     = serial_mode && read_after_convert;
					n.div     = (serial_mode && read_after_convert) ? serial_clock_divider : 2'h0;
					n.started = 1'b0;
				end
			end
			adc_timing_pkg::C_CONV:
			begin
				n.cnt = r.cnt + 8'h01;
				if (r.rac)
				begin
					if (r.cnt == adc_timing_pkg::rac_cycles(r.mode))
					begin
						capture = 1'b1;
						n.conv  = adc_timing_pkg::C_READ;
					end
				end
				else
				begin
					// Result lands one cycle before busy falls.
					if (r.cnt == adc_timing_pkg::conv_cycles(r.mode) - 8'h01)
						capture = 1'b1;
					if (r.cnt == adc_timing_pkg::conv_cycles(r.mode))
					begin
						n.busy = 1'b0;
						n.conv = adc_timing_pkg::C_IDLE;
					end
				end
			end
			adc_timing_pkg::C_READ:
			begin
				// Busy drops the cycle after the frame has closed.
				if (r.started && (r.ser == adc_timing_pkg::S_IDLE))
				begin
					n.busy = 1'b0;
					n.conv = adc_timing_pkg::C_IDLE;
				end
			end
			default:
			begin
				n.conv = adc_timing_pkg::C_IDLE;
			end
		endcase
		if (capture)
		begin
			n.par_data = conv_result;
			fifo_push  = 1'b1;
		end
		// Frame launch: previous result during conversion, or this one after it.
		frame_go = serial_mode && fifo_out_valid && (r.ser == adc_timing_pkg::S_IDLE)
			&& (((r.conv == adc_timing_pkg::C_CONV) && !r.rac
			&& (r.cnt == adc_timing_pkg::rdc_cycles(r.mode)))
			|| ((r.conv == adc_timing_pkg::C_READ) && !r.started));
		// A parallel reader consumes the queued word when it releases the bus.
		if (!serial_mode && r.req_prev && !par_req && fifo_out_valid)
			fifo_pop = 1'b1;
		unique case (r.ser)
			adc_timing_pkg::S_IDLE:
			begin
				if (frame_go)
				begin
					fifo_pop    = 1'b1;
					n.shreg     = fifo_out_data;
					n.sdo       = fifo_out_data[13];
					n.sync      = 1'b1;
					n.sclk      = 1'b0;
					n.bit_idx   = 4'h0;
					n.tick_cnt  = 4'h0;
					n.phase_cnt = 4'h1;
					n.fdiv      = r.div;
					n.ser       = adc_timing_pkg::S_LEAD;
					if (r.conv == adc_timing_pkg::C_READ)
						n.started = 1'b1;
				end
			end
			adc_timing_pkg::S_LEAD:
			begin
				// Clock stays low while sync leads.
				n.phase_cnt = r.phase_cnt + 4'h1;
				if (r.phase_cnt >= adc_timing_pkg::LEAD_CYC)
					n.ser = adc_timing_pkg::S_SHIFT;
			end
			adc_timing_pkg::S_SHIFT:
			begin
				if (r.tick_cnt == half_last)
				begin
					n.tick_cnt = 4'h0;
					if (!r.sclk)
					begin
						n.sclk = 1'b1;
					end
					else
					begin
						n.sclk = 1'b0;
						if (r.bit_idx == adc_timing_pkg::LAST_BIT)
						begin
							n.ser       = adc_timing_pkg::S_HOLD;
							n.phase_cnt = 4'h1;
						end
						else
						begin
							n.shreg   = {r.shreg[12:0], 1'b0};
							n.sdo     = r.shreg[12];
							n.bit_idx = r.bit_idx + 4'h1;
						end
					end
				end
				else
				begin
					n.tick_cnt = r.tick_cnt + 4'h1;
				end
			end
			adc_timing_pkg::S_HOLD:
			begin
				// Sync outlasts the last falling clock edge.
				n.phase_cnt = r.phase_cnt + 4'h1;
				if (r.phase_cnt >= adc_timing_pkg::HOLD_CYC)
				begin
					n.sync = 1'b0;
					n.ser  = adc_timing_pkg::S_IDLE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			r <= adc_timing_pkg::CTRL_RESET;
		else
			r <= n;
	end

	// Outputs straight from the state flops.
	assign busy                   = r.busy;
	assign par_data_out           = r.par_data;
	assign par_data_oe_n          = r.par_oe_n;
	assign frame_sync_out         = r.sync;
	assign frame_sync_oe_n        = r.ser_oe_n;
	assign serial_data_clock      = r.sclk;
	assign serial_data_clock_oe_n = r.ser_oe_n;
	assign serial_result_out      = r.sdo;
	assign serial_result_oe_n     = r.ser_oe_n;

	// Busy run length, read only by the checks below.
	logic [7:0] busy_run_reg;
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			busy_run_reg <= 8'h00;
		else
			busy_run_reg <= r.busy ? busy_run_reg + 8'h01 : 8'h00;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_busy_rise;
		start |=> r.busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise after start");

	property p_busy_width;
		r.busy && !r.rac |-> busy_run_reg < adc_timing_pkg::conv_cycles(r.mode);
	endproperty
	a_busy_width: assert property (p_busy_width) else $error("busy held too long");

	property p_data_at_busy_fall;
		$fell(r.busy) && !r.rac |-> $stable(r.par_data) && r.par_data == $past(conv_result, 2);
	endproperty
	a_data_at_busy_fall: assert property (p_data_at_busy_fall) else $error("late result");

	property p_par_drive;
		par_req |=> !par_data_oe_n;
	endproperty
	a_par_drive: assert property (p_par_drive) else $error("parallel bus not driven");

	// A released request must float the bus on the very next edge.
	property p_par_float;
		!par_req |=> par_data_oe_n;
	endproperty
	a_par_float: assert property (p_par_float) else $error("parallel bus not released");

	property p_ser_float;
		(cs_n || !serial_mode) |=> r.ser_oe_n;
	endproperty
	a_ser_float: assert property (p_ser_float) else $error("serial pins not floated");

	property p_rdc_sync;
		$rose(r.sync) && $past(r.conv) == adc_timing_pkg::C_CONV
			|-> $past(r.cnt) == adc_timing_pkg::rdc_cycles($past(r.mode));
	endproperty
	a_rdc_sync: assert property (p_rdc_sync) else $error("sync delay wrong");

	property p_sync_lead;
		$rose(r.sync) |-> !r.sclk ##1 !r.sclk;
	endproperty
	a_sync_lead: assert property (p_sync_lead) else $error("clock edge too soon");

	property p_sync_hold;
		$fell(r.sync) |-> !r.sclk && !$past(r.sclk);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync fell too soon");

	property p_fast_clock;
		r.fdiv == 2'h0 && r.ser == adc_timing_pkg::S_SHIFT
			&& $past(r.ser) == adc_timing_pkg::S_SHIFT |-> $changed(r.sclk);
	endproperty
	a_fast_clock: assert property (p_fast_clock) else $error("serial clock too slow");

	property p_rac_busy_end;
		$fell(r.sync) && r.conv == adc_timing_pkg::C_READ |-> r.busy ##1 !r.busy;
	endproperty
	a_rac_busy_end: assert property (p_rac_busy_end) else $error("busy tail wrong");

	c_rdc_frame: cover property ($rose(r.sync) && !r.rac);
	c_rac_frame: cover property ($fell(r.busy) && r.rac);
	c_par_read: cover property ($fell(par_data_oe_n));
	c_fifo_full: cover property (!fifo_in_ready);

endmodule : adc_conversion_output_timing

`default_nettype wire

// ==== host_serial_rx.sv ====
`timescale 1ns/1ps
`default_nettype none

// Host side of the master serial port: resolves the three lines, collects the word
// and measures the framing in clock cycles.
module host_serial_rx
(
	// Clock and reset.
	input  wire logic   clock,
	input  wire logic   sys_rst,
	// Lines from the converter.
	input  wire logic   sync,
	input  wire logic   sync_oe_n,
	input  wire logic   sclk,
	input  wire logic   sclk_oe_n,
	input  wire logic   sdo,
	input  wire logic   sdo_oe_n,
	input  wire logic   busy,
	// Measurements of the last frame, and the count of frames seen.
	output logic [13:0] word,
	output logic [7:0]  bits,
	output logic [7:0]  lead,
	output logic [7:0]  tail,
	output logic [7:0]  hi_min,
	output logic [7:0]  hi_max,
	output logic [7:0]  gap,
	output logic [7:0]  frames
);
	logic       s_last, c_last, d_last, c_prev, in_frame, gap_on;
	logic       s_w, c_w, d_w;
	logic [7:0] run, gap_cnt;

	// A floating line shows the inverse of its last driven level, so a float never reads as data.
	assign s_w = sync_oe_n ? ~s_last : sync;
	assign c_w = sclk_oe_n ? ~c_last : sclk;
	assign d_w = sdo_oe_n ? ~d_last : sdo;

	// Start from a quiet state so the first frame is measured cleanly.
	initial
	begin
		{s_last, c_last, d_last, c_prev, in_frame, gap_on} = '0;
		{word, bits, lead, tail, hi_min, hi_max, gap, frames, run, gap_cnt} = '0;
	end

	// Sampling on the rising edge sees the registered outputs of the previous cycle.
	always @(posedge clock)
	begin
		if (!sync_oe_n) s_last <= sync;
		if (!sclk_oe_n) c_last <= sclk;
		if (!sdo_oe_n) d_last <= sdo;
		if (sys_rst)
		begin
			in_frame = 1'b0;
			gap_on = 1'b0;
		end
		else if (!in_frame)
		begin
			if (s_w)
			begin
				in_frame = 1'b1;
				{bits, tail, run, hi_max, c_prev} = '0;
				lead = 8'h01;
				hi_min = 8'hff;
			end
		end
		else if (s_w)
		begin
			if (c_w)
			begin
				if (!c_prev)
				begin
					word = {word[12:0], d_w};
					bits++;
					run = 8'h00;
				end
				run++;
				tail = 8'h00;
			end
			else
			begin
				if (c_prev && run < hi_min) hi_min = run;
				if (c_prev && run > hi_max) hi_max = run;
				if (bits == 0) lead++;
				else tail++;
			end
			c_prev = c_w;
		end
		else
		begin
			in_frame = 1'b0;
			frames++;
			gap_on = 1'b1;
			gap_cnt = 8'h00;
		end
		// Cycles from the first low sync sample until busy is seen low.
		if (gap_on)
		begin
			if (!busy)
			begin
				gap = gap_cnt;
				gap_on = 1'b0;
			end
			else gap_cnt++;
		end
	end
endmodule : host_serial_rx

`default_nettype wire

// ==== adc_conversion_output_timing_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_output_timing_tb;
	logic        clock, sys_rst, convert_start_n, fastest_select, low_power_select, busy;
	logic        cs_n, rd_n, par_data_oe_n, serial_mode, read_after_convert;
	logic [13:0] conv_result, par_data_out, word;
	logic [1:0]  serial_clock_divider;
	logic        frame_sync_out, frame_sync_oe_n, serial_data_clock, serial_data_clock_oe_n;
	logic        serial_result_out, serial_result_oe_n;
	logic [7:0]  bits, lead, tail, hi_min, hi_max, gap, frames;
	int          err_total, checked, cyc;
	logic [1:0]  sel_t [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
	int          k_t [4] = '{8, 11, 13, 11};
	int          r_t [4] = '{1, 2, 5, 2};

	adc_conversion_output_timing adc_conversion_output_timing_inst (.clock(clock),
		.sys_rst(sys_rst), .convert_start_n(convert_start_n), .fastest_select(fastest_select),
		.low_power_select(low_power_select), .conv_result(conv_result), .busy(busy),
		.cs_n(cs_n), .rd_n(rd_n), .par_data_out(par_data_out), .par_data_oe_n(par_data_oe_n),
		.serial_mode(serial_mode), .read_after_convert(read_after_convert),
		.serial_clock_divider(serial_clock_divider), .frame_sync_out(frame_sync_out),
		.frame_sync_oe_n(frame_sync_oe_n), .serial_data_clock(serial_data_clock),
		.serial_data_clock_oe_n(serial_data_clock_oe_n),
		.serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n));

	host_serial_rx host_serial_rx_inst (.clock(clock), .sys_rst(sys_rst),
		.sync(frame_sync_out), .sync_oe_n(frame_sync_oe_n), .sclk(serial_data_clock),
		.sclk_oe_n(serial_data_clock_oe_n), .sdo(serial_result_out),
		.sdo_oe_n(serial_result_oe_n), .busy(busy), .word(word), .bits(bits), .lead(lead),
		.tail(tail), .hi_min(hi_min), .hi_max(hi_max), .gap(gap), .frames(frames));

	// Free-running 10 MHz clock.
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic end_of_test();
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// A hung wait ends the run as a failure instead of stalling forever.
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			end_of_test();
		end
	end

	task automatic reset_dut();
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (6) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
	endtask : reset_dut

	// Mode selects settle a cycle ahead; the start is low for exactly one sample.
	task automatic start_conv(input logic [1:0] sel, input logic [13:0] res);
		@(negedge clock);
		{fastest_select, low_power_select} = sel;
		conv_result = res;
		@(negedge clock);
		convert_start_n = 1'b0;
		@(negedge clock);
		convert_start_n = 1'b1;
	endtask : start_conv

	// Parallel conversion; rd holds a bus request over it, again retries the start while busy.
	task automatic par_conv(input logic [1:0] sel, input logic [13:0] res, input int k,
		input logic rd, input logic again);
		int hi;
		int first;
		hi = 0;
		first = 99;
		cs_n = !rd;
		rd_n = !rd;
		start_conv(sel, res);
		if (rd) check(par_data_oe_n, 1'b0);
		for (int i = 1; i <= 18; i++)
		begin
			if (busy === 1'b1)
			begin
				if (first == 99) first = i;
				hi++;
				if (rd && hi == k) check(par_data_out, res);
			end
			if (again) convert_start_n = !(i == 3);
			@(negedge clock);
		end
		check(first <= 2, 1'b1);
		check(16'(hi), 16'(k));
		cs_n = 1'b1;
		rd_n = 1'b1;
		repeat (2) @(negedge clock);
		check(par_data_oe_n, 1'b1);
	endtask : par_conv

	task automatic wait_frame(input logic [7:0] f);
		int n;
		n = 0;
		while (frames == f && n < 600)
		begin
			@(negedge clock);
			n++;
		end
		repeat (3) @(negedge clock);
	endtask : wait_frame

	task automatic to_sync(output int n);
		n = 1;
		while (frame_sync_out !== 1'b1 && n < 400)
		begin
			@(negedge clock);
			n++;
		end
	endtask : to_sync

	task automatic serial_setup(input logic rac, input logic [1:0] d);
		reset_dut();
		serial_mode = 1'b1;
		read_after_convert = rac;
		serial_clock_divider = d;
		cs_n = 1'b0;
		rd_n = 1'b0;
		repeat (2) @(negedge clock);
		check({frame_sync_oe_n, serial_data_clock_oe_n, serial_result_oe_n}, 3'b000);
	endtask : serial_setup

	task automatic rac(input logic [1:0] d, input logic [13:0] res);
		int n;
		logic [7:0] f;
		serial_setup(1'b1, d);
		f = frames;
		start_conv(2'b10, res);
		to_sync(n);
		check(n >= 7 && n <= 11, 1'b1);
		wait_frame(f);
		check(word, res);
		check(bits, 8'd14);
		check(hi_min, 8'h01 << d);
		check(hi_max, 8'h01 << d);
		check(lead, 8'h01 + (8'h01 << d));
		check(tail, 8'h01);
		check(gap, 8'h01);
		check(par_data_oe_n, 1'b1);
		cs_n = 1'b1;
		repeat (2) @(negedge clock);
		check({frame_sync_oe_n, serial_data_clock_oe_n, serial_result_oe_n}, 3'b111);
	endtask : rac

	// The divider is set slow on purpose: read-during-convert must ignore it.
	task automatic rdc(input int m);
		int n;
		logic [7:0] f;
		serial_setup(1'b0, 2'b11);
		f = frames;
		start_conv(sel_t[m], 14'h0a5a + 14'(m));
		repeat (k_t[m] + 4) @(negedge clock);
		check(frames == f, 1'b1);
		start_conv(sel_t[m], 14'h3c3c);
		to_sync(n);
		check(n >= r_t[m] && n <= r_t[m] + 3, 1'b1);
		check(busy, 1'b1);
		wait_frame(f);
		check(word, 14'h0a5a + 14'(m));
		check({hi_min, hi_max}, 16'h0101);
	endtask : rdc

	// Main sequence: parallel modes, buffer fill and drain, then both serial readouts.
	initial
	begin
		{sys_rst, convert_start_n, cs_n, rd_n} = 4'hf;
		{fastest_select, low_power_select, serial_mode, read_after_convert} = 4'h0;
		conv_result = 14'h0000;
		serial_clock_divider = 2'h0;
		err_total = 0;
		checked = 0;
		cyc = 0;
		repeat (6) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		check({busy, par_data_oe_n, frame_sync_oe_n, frame_sync_out}, 4'h6);
		for (int i = 0; i < 4; i++)
			par_conv(sel_t[i], 14'h2a5c ^ 14'(i), k_t[i], 1'b1, i == 0);
		// The buffer holds 17 words: 16 in memory plus its head register.
		for (int i = 0; i < 17; i++)
			par_conv(2'b10, 14'(i), 8, 1'b0, 1'b0);
		start_conv(2'b10, 14'h3fff);
		repeat (3)
		begin
			check(busy, 1'b0);
			@(negedge clock);
		end
		repeat (17)
		begin
			{cs_n, rd_n} = 2'b00;
			@(negedge clock);
			{cs_n, rd_n} = 2'b11;
			@(negedge clock);
		end
		par_conv(2'b10, 14'h1357, 8, 1'b1, 1'b0);
		for (int d = 0; d < 4; d++)
			rac(2'(d), 14'h2b4d ^ 14'(d));
		for (int m = 0; m < 3; m++)
			rdc(m);
		end_of_test();
	end
endmodule : adc_conversion_output_timing_tb

`default_nettype wire
